/* fps_defs.vh */
// Constants for the fault protection sequencer
`ifndef FPS_DEFS_VH
`define FPS_DEFS_VH
`define FPS_CLK_MHZ 250
`define FPS_STEP_MS 10
`define FPS_STEP_CYC (`FPS_STEP_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_SS_MS 4
`define FPS_SS_CYC (`FPS_SS_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_OVL_LIMIT 4'h8
`define FPS_CNT_W 32
`define FPS_VAR_A 2'h0
`define FPS_VAR_B 2'h1
`define FPS_VAR_C 2'h2
`define FPS_VAR_D 2'h3
`define FPS_ADDR_CTRL 4'h0
`define FPS_ADDR_STAT 4'h1
`define FPS_ADDR_MASK 4'h2
`define FPS_ADDR_STATE 4'h3
`define FPS_CTRL_RESET 8'h00
`define FPS_IRQ_OVL 0
`define FPS_IRQ_SHORT 1
`define FPS_IRQ_OTP 2
`define FPS_IRQ_OVP 3
`define FPS_IRQ_BO 4
`define FPS_IRQ_LATCH 5
`define FPS_IRQ_W 6
`endif

/* fps_tick.v */
// Free-running divider producing a one-cycle step pulse
`timescale 1ns/10ps
`include "fps_defs.vh"
module fps_tick #(
   parameter [31:0] PERIOD = 32'h0000_0010
) (
   input wire i_clock,
   input wire i_rst_b,
   input wire i_clear,
   output reg o_tick
);
   reg [31:0] cnt_r;
   always @(posedge i_clock) begin
      if (!i_rst_b || i_clear) begin
         cnt_r <= 32'h0000_0000;
         o_tick <= 1'b0;
      end else if (cnt_r >= PERIOD - 32'h0000_0001) begin
         cnt_r <= 32'h0000_0000;
         o_tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h0000_0001;
         o_tick <= 1'b0;
      end
   end
endmodule // fps_tick

/* fps_ovl_timer.v */
// Up/down overload timer counting step pulses
`timescale 1ns/10ps
`include "fps_defs.vh"
module fps_ovl_timer (
   input wire i_clock,
   input wire i_rst_b,
   input wire i_clear,
   input wire i_step,
   input wire i_overcurrent,
   output reg [3:0] o_count,
   output reg o_expired
);
   always @(posedge i_clock) begin
      if (!i_rst_b || i_clear) begin
         o_count <= 4'h0;
         o_expired <= 1'b0;
      end else if (!o_expired && i_step) begin
         if (i_overcurrent) begin
            o_count <= o_count + 4'h1;
            if (o_count + 4'h1 == `FPS_OVL_LIMIT)
               o_expired <= 1'b1;
         end else if (o_count != 4'h0) begin
            o_count <= o_count - 4'h1;
         end
      end
   end
endmodule // fps_ovl_timer

/* fps_seq.v */
// Fault protection sequencer top: fault decisions, startup, registers
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/10ps
`include "fps_defs.vh"
// Overview of operation
// - While overcurrent is reported, overload count rises once per 10 ms step.
// - With overcurrent quiet, overload count falls once per 10 ms step.
// - Eight accumulated steps (80 ms) mean the overload timer has expired.
// - Variants B and D: expiry halts switching; supply discharges on its own.
// - Auto-recovery restarts with startup once supply-off indication is seen.
// - Variants A and C: expiry stops gate drive and asserts supply clamp.
// - Winding-short comparator shuts the controller down immediately.
// - Winding-short shutdown latches or auto-recovers like overload does.
// - Variants A and B: over-temperature on fault pin latches off.
// - Overvoltage on fault pin latches off, stops gate, clamps supply.
// - Latch holds until supply current drops below latch-hold level.
// - C/D use fault pin for brown-out and overvoltage; A/B for temperature and overvoltage.
// - C/D: brown-out comparator high stops switching.
// - After brown-out, resume only at supply turn-on with full soft-start.
// - C/D: hysteresis current source is on while brown-out comparator is high.
// - All variants: overvoltage latches until supply current drops below latch-hold level.
// - Every startup or restart applies a fixed 4 ms soft-start.
// - Winding-short comparator honoured only inside main blanking window.
module fps_seq #(
   parameter [31:0] STEP_CYC = `FPS_STEP_CYC,
   parameter [31:0] SS_CYC = `FPS_SS_CYC
) (
   input wire i_clock,
   input wire i_rst_b,
   input wire [1:0] i_variant,
   input wire i_overcurrent_comparator,
   input wire i_short_comparator,
   input wire i_main_blanking_time,
   input wire i_otp_comparator,
   input wire i_ovp_comparator,
   input wire i_brownout_comparator,
   input wire i_vcc_on,
   input wire i_vcc_off,
   input wire i_below_latch_hold_current,
   input wire [3:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   output wire o_gate_enable,
   output wire o_soft_start,
   output wire o_supply_clamp,
   output wire o_bo_hyst_enable,
   output wire o_irq
);
   localparam [4:0] ST_OFF = 5'h01;
   localparam [4:0] ST_SOFT = 5'h02;
   localparam [4:0] ST_RUN = 5'h04;
   localparam [4:0] ST_HALT = 5'h08;
   localparam [4:0] ST_LATCH = 5'h10;

   reg [4:0] state_r;
   reg [4:0] state_nxt;
   reg [31:0] ss_cnt_r;
   reg [`FPS_IRQ_W-1:0] stat_r;
   reg [`FPS_IRQ_W-1:0] mask_r;
   reg [7:0] ctrl_r;
   reg ovc_seen_r;
   wire step;
   wire [3:0] ovl_count;
   wire ovl_expired;
   wire latching;
   wire cd_var;
   wire short_hit;
   wire otp_hit;
   wire ovp_hit;
   wire bo_hit;
   wire running;
   wire timer_clear;
   wire [`FPS_IRQ_W-1:0] events;
   wire [`FPS_IRQ_W-1:0] clr_bits;

   // Variants A and C latch overload and short faults
   assign latching = (i_variant == `FPS_VAR_A) || (i_variant == `FPS_VAR_C);
   assign cd_var = (i_variant == `FPS_VAR_C) || (i_variant == `FPS_VAR_D);
   assign running = (state_r == ST_SOFT) || (state_r == ST_RUN);
   assign short_hit = running && i_short_comparator && i_main_blanking_time;
   assign otp_hit = running && !cd_var && i_otp_comparator;
   assign ovp_hit = running && i_ovp_comparator;
   assign bo_hit = running && cd_var && i_brownout_comparator;
   assign o_bo_hyst_enable = cd_var && i_brownout_comparator;
   assign timer_clear = !running;

   fps_tick #(
      .PERIOD(STEP_CYC)
   ) u_tick (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_clear(timer_clear),
      .o_tick(step)
   );

   // Remember any overcurrent within a step so short pulses still count
   always @(posedge i_clock) begin
      if (!i_rst_b || timer_clear || step)
         ovc_seen_r <= 1'b0;
      else if (i_overcurrent_comparator)
         ovc_seen_r <= 1'b1;
   end

   fps_ovl_timer u_ovl (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_clear(timer_clear),
      .i_step(step),
      .i_overcurrent(ovc_seen_r || i_overcurrent_comparator),
      .o_count(ovl_count),
      .o_expired(ovl_expired)
   );

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_OFF: begin
            if (i_vcc_on && !(cd_var && i_brownout_comparator))
               state_nxt = ST_SOFT;
         end
         ST_SOFT, ST_RUN: begin
            if (ovp_hit || otp_hit)
               state_nxt = ST_LATCH;
            else if ((ovl_expired || short_hit) && latching)
               state_nxt = ST_LATCH;
            else if (ovl_expired || short_hit)
               state_nxt = ST_HALT;
            else if (bo_hit)
               state_nxt = ST_OFF;
            else if (state_r == ST_SOFT && ss_cnt_r >= SS_CYC - 32'h0000_0001)
               state_nxt = ST_RUN;
         end
         ST_HALT: begin
            if (i_vcc_off)
               state_nxt = ST_OFF;
         end
         ST_LATCH: begin
            if (i_below_latch_hold_current)
               state_nxt = ST_OFF;
         end
         default: state_nxt = ST_OFF;
      endcase
   end

   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         state_r <= ST_OFF;
         ss_cnt_r <= 32'h0000_0000;
      end else begin
         state_r <= state_nxt;
         if (state_r == ST_SOFT)
            ss_cnt_r <= ss_cnt_r + 32'h0000_0001;
         else
            ss_cnt_r <= 32'h0000_0000;
      end
   end

   // Software force-off bit overrides drive without touching the state
   assign o_gate_enable = running && !ctrl_r[0];
   assign o_soft_start = (state_r == ST_SOFT);
   assign o_supply_clamp = (state_r == ST_LATCH);

   assign events = {(state_nxt == ST_LATCH) && (state_r != ST_LATCH), bo_hit, ovp_hit,
                    otp_hit, short_hit, ovl_expired && running};
   assign clr_bits = (i_wr && i_addr == `FPS_ADDR_STAT) ? i_wdata[`FPS_IRQ_W-1:0]
                                                          : {`FPS_IRQ_W{1'b0}};

   // Set wins over a simultaneous write-one clear
   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         stat_r <= {`FPS_IRQ_W{1'b0}};
         mask_r <= {`FPS_IRQ_W{1'b0}};
         ctrl_r <= `FPS_CTRL_RESET;
      end else begin
         stat_r <= (stat_r & ~clr_bits) | events;
         if (i_wr && i_addr == `FPS_ADDR_MASK)
            mask_r <= i_wdata[`FPS_IRQ_W-1:0];
         if (i_wr && i_addr == `FPS_ADDR_CTRL)
            ctrl_r <= i_wdata;
      end
   end

   assign o_irq = |(stat_r & mask_r);

   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            `FPS_ADDR_CTRL: o_rdata <= ctrl_r;
            `FPS_ADDR_STAT: o_rdata <= {2'h0, stat_r};
            `FPS_ADDR_MASK: o_rdata <= {2'h0, mask_r};
            `FPS_ADDR_STATE: o_rdata <= {ovl_count, 1'b0, state_r[4:2]};
            default: o_rdata <= 8'h00;
         endcase
      end else begin
         o_rdata <= 8'h00;
      end
   end
endmodule // fps_seq

/* fps_seq_chk.sv */
// Port-level assertions for the fault sequencer
`timescale 1ns/10ps
module fps_seq_chk (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic [1:0] i_variant,
   input wire logic i_short_comparator,
   input wire logic i_main_blanking_time,
   input wire logic i_otp_comparator,
   input wire logic i_ovp_comparator,
   input wire logic i_brownout_comparator,
   input wire logic i_below_latch_hold_current,
   input wire logic o_gate_enable,
   input wire logic o_soft_start,
   input wire logic o_supply_clamp,
   input wire logic o_bo_hyst_enable
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   sequence s_off;
      !o_gate_enable && !o_soft_start;
   endsequence
   ovp_latch_a: assert property (i_ovp_comparator && o_gate_enable |=> s_off ##0 o_supply_clamp)
      else $error("overvoltage did not latch");
   otp_latch_a: assert property (i_otp_comparator && !i_variant[1] && o_gate_enable |=> o_supply_clamp)
      else $error("over-temperature did not latch");
   // Overvoltage latches on every variant and over-temperature on A and B; both take priority, so they are kept out here
   short_stop_a: assert property (i_short_comparator && i_main_blanking_time && o_gate_enable
      && !i_ovp_comparator && !(i_otp_comparator && !i_variant[1])
      |=> s_off ##0 (o_supply_clamp == !i_variant[0])) else $error("winding short mishandled");
   bo_stop_a: assert property (i_brownout_comparator && i_variant[1] |=> !o_gate_enable)
      else $error("brown-out did not stop switching");
   hyst_src_a: assert property (o_bo_hyst_enable == (i_variant[1] && i_brownout_comparator))
      else $error("hysteresis source wrong");
   latch_hold_a: assert property (o_supply_clamp && !i_below_latch_hold_current |=> o_supply_clamp)
      else $error("latch released early");
   clamp_gate_a: assert property (o_supply_clamp |-> s_off)
      else $error("gate active while clamped");
   // Eight cycles is below any soft-start setting in use
   soft_start_a: assert property ($rose(o_soft_start) |-> o_gate_enable throughout o_soft_start [*8])
      else $error("soft-start cut short");
endmodule // fps_seq_chk

/* fps_supply_model.sv */
// Supply rail model: charges while idle, sags after a halt
`timescale 1ns/10ps
module fps_supply_model (
   input wire logic i_clock,
   input wire logic i_power,
   input wire logic i_gate,
   input wire logic i_clamp,
   output logic o_vcc_on,
   output logic o_vcc_off,
   output logic o_below_hold
);
   logic [3:0] lvl_r = 4'h0;
   logic sag_r = 1'b0;
   logic gate_r = 1'b0;
   // Clamped rail holds its level, so a latch never restarts by itself
   always @(posedge i_clock) begin
      gate_r <= i_gate;
      if (!i_power) {lvl_r, sag_r} <= 5'h00;
      else if (gate_r && !i_gate && !i_clamp) sag_r <= 1'b1;
      else if (sag_r) {lvl_r, sag_r} <= (lvl_r == 4'h0) ? 5'h00 : {lvl_r - 4'h1, 1'b1};
      else if (!i_gate && !i_clamp && lvl_r != 4'hF) lvl_r <= lvl_r + 4'h1;
   end
   assign o_vcc_on = lvl_r == 4'hF && !sag_r;
   assign o_vcc_off = sag_r && lvl_r == 4'h0;
   assign o_below_hold = !i_power;
endmodule // fps_supply_model

/* fps_seq_test.sv */
// Directed bench for the fault protection sequencer
`timescale 1ns/10ps
module fps_seq_test;
   logic i_clock = 0, i_rst_b = 0, i_wr = 0, i_rd = 0, pwr = 0, i_overcurrent_comparator = 0;
   logic i_short_comparator = 0, i_main_blanking_time = 0, i_otp_comparator = 0;
   logic i_ovp_comparator = 0, i_brownout_comparator = 0;
   logic [1:0] i_variant = 0;
   logic [3:0] i_addr = 0;
   logic [7:0] i_wdata = 0, o_rdata;
   logic o_gate_enable, o_soft_start, o_supply_clamp, o_bo_hyst_enable, o_irq;
   logic i_vcc_on, i_vcc_off, i_below_latch_hold_current;
   wire [3:0] st = {o_irq, o_supply_clamp, o_soft_start, o_gate_enable};
   int err_total = 0, n_tests = 0, n;
   fps_seq #(.STEP_CYC(32'h14), .SS_CYC(32'hA)) dut (.*);
   fps_supply_model model (.i_clock, .i_power(pwr), .i_gate(o_gate_enable),
      .i_clamp(o_supply_clamp), .o_vcc_on(i_vcc_on), .o_vcc_off(i_vcc_off),
      .o_below_hold(i_below_latch_hold_current));
   initial forever #2 i_clock = ~i_clock;
   task automatic chk(input string nm, input logic [7:0] e, g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task print_verdict;
      $display("mismatches %0d checks %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Bounded wait on one output; n returns the cycles spent
   task automatic wt(input int s, input logic v);
      n = 0;
      while (st[s] !== v && n < 400) begin
         @(posedge i_clock);
         #1 n++;
      end
      if (st[s] !== v) begin
         chk("wait", v, st[s]);
         print_verdict;
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clock);
      {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
      @(posedge i_clock);
      i_wr <= 0;
   endtask
   task automatic rreg(input logic [3:0] a, input logic [7:0] e, input string nm);
      @(posedge i_clock);
      {i_addr, i_rd} <= {a, 1'b1};
      @(posedge i_clock);
      i_rd <= 0;
      #1 chk(nm, e, o_rdata);
   endtask
   task automatic boot(input logic [1:0] v);
      @(posedge i_clock);
      {i_rst_b, pwr, i_overcurrent_comparator, i_brownout_comparator} <= 0;
      {i_otp_comparator, i_ovp_comparator, i_short_comparator, i_main_blanking_time} <= 0;
      i_variant <= v;
      repeat (12) @(posedge i_clock);
      {i_rst_b, pwr} <= 2'h3;
      wt(1, 1);
      wt(1, 0);
      chk("soft start", 1, n > 8 && n < 12);
   endtask
   task automatic trip(input logic [1:0] v, input logic [3:0] f, input logic g, c);
      boot(v);
      @(posedge i_clock);
      {i_otp_comparator, i_ovp_comparator, i_short_comparator, i_main_blanking_time} <= f;
      repeat (3) @(posedge i_clock);
      #1 chk("gate", g, o_gate_enable);
      chk("clamp", c, o_supply_clamp);
   endtask
   initial begin
      boot(2'h0);
      wreg(4'h3, 8'hFF);
      rreg(4'h3, 8'h01, "state");
      rreg(4'hF, 8'h00, "unmapped");
      wreg(4'h2, 8'h3F);
      rreg(4'h2, 8'h3F, "mask");
      wreg(4'h0, 8'h01);
      #1 chk("force off", 0, o_gate_enable);
      rreg(4'h0, 8'h01, "ctrl");
      wreg(4'h0, 8'h00);
      #1 chk("force release", 1, o_gate_enable);
      @(posedge i_clock) i_overcurrent_comparator <= 1;
      wt(2, 1);
      chk("expiry time", 1, n > 138 && n < 165);
      chk("gate", 0, o_gate_enable);
      chk("irq", 1, o_irq);
      rreg(4'h1, 8'h21, "status");
      @(posedge i_clock) i_overcurrent_comparator <= 0;
      wreg(4'h1, 8'h21);
      rreg(4'h1, 8'h00, "status clear");
      chk("irq clear", 0, o_irq);
      repeat (40) @(posedge i_clock);
      #1 chk("latch hold", 1, o_supply_clamp);
      @(posedge i_clock) pwr <= 0;
      wt(2, 0);
      boot(2'h0);
      @(posedge i_clock) i_overcurrent_comparator <= 1;
      repeat (80) @(posedge i_clock);
      i_overcurrent_comparator <= 0;
      repeat (80) @(posedge i_clock);
      i_overcurrent_comparator <= 1;
      repeat (80) @(posedge i_clock);
      #1 chk("no early expiry", 0, o_supply_clamp);
      wt(2, 1);
      boot(2'h1);
      @(posedge i_clock) i_overcurrent_comparator <= 1;
      wt(0, 0);
      chk("halt clamp", 0, o_supply_clamp);
      @(posedge i_clock) i_overcurrent_comparator <= 0;
      wt(1, 1);
      trip(2'h0, 4'h8, 0, 1);
      trip(2'h2, 4'h8, 1, 0);
      trip(2'h1, 4'h4, 0, 1);
      trip(2'h3, 4'h4, 0, 1);
      trip(2'h3, 4'h2, 1, 0);
      trip(2'h3, 4'h3, 0, 0);
      trip(2'h2, 4'h3, 0, 1);
      boot(2'h2);
      @(posedge i_clock) i_brownout_comparator <= 1;
      @(posedge i_clock);
      #1 chk("bo gate", 0, o_gate_enable);
      chk("hyst", 1, o_bo_hyst_enable);
      @(posedge i_clock) i_brownout_comparator <= 0;
      repeat (3) @(posedge i_clock);
      #1 chk("early restart", 0, o_gate_enable);
      wt(1, 1);
      print_verdict;
   end
endmodule // fps_seq_test
bind fps_seq fps_seq_chk u_chk (.i_clock, .i_rst_b, .i_variant, .i_short_comparator,
   .i_main_blanking_time, .i_otp_comparator, .i_ovp_comparator, .i_brownout_comparator,
   .i_below_latch_hold_current, .o_gate_enable, .o_soft_start, .o_supply_clamp,
   .o_bo_hyst_enable);
